/* core/asq_pkg.sv */
package asq_pkg;

  // timebase
  localparam int CLK_HZ      = 100_000_000;
  localparam int MAX_RATE_HZ = 250_000;
  localparam int BURST_CYC   = CLK_HZ / MAX_RATE_HZ;  // cycles per burst step
  localparam int NCH         = 16;
  localparam int STORE_DEPTH = 4096;
  localparam int STAGE_DEPTH = 8;
  localparam int SMP_W       = 20;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHEN = 8'h04;
  localparam logic [7:0] ADDR_INTV = 8'h08;
  localparam logic [7:0] ADDR_CMD  = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_DATA = 8'h14;

  // command bits
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;
  localparam int CMD_CLR   = 2;

  // status field positions
  localparam int STAT_HALT = 2;
  localparam int STAT_FULL = 3;
  localparam int STAT_IRQ  = 4;
  localparam int STAT_CNT  = 16;
  localparam int DATA_VLD  = 31;

  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] CHEN_RST = 16'h0001;
  localparam logic [31:0] INTV_RST = 32'h0001_86A0;  // 1 kHz

  // fill thresholds: level code 7 value, and base shifted by codes 0 to 6
  localparam logic [12:0] THR_TOP = 13'h0800;
  localparam logic [12:0] THR_MIN = 13'h0008;

  typedef enum logic [1:0] {
    SRC_SW  = 2'b00,
    SRC_INT = 2'b01,
    SRC_EXT = 2'b10
  } asq_src_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN   = 2'b10
  } asq_state_t;

  // control register layout, bits 7:0
  typedef struct packed {
    logic [2:0] lvl;        // fill-level code
    logic       irq_en;     // interrupt transfer mode
    logic       edge_fall;  // external edge select
    asq_src_t   src;        // trigger source
    logic       burst;      // burst scan mode
  } asq_ctrl_t;

  typedef struct packed {
    logic [3:0]  ch;
    logic [15:0] data;
  } asq_smp_t;

endpackage

/* core/asq_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module asq_fifo import asq_pkg::*; #(
  parameter int W     = 20,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,    // system clock
  input  wire logic         rst_n,      // async reset
  input  wire logic         clr,        // flush contents
  input  wire logic         in_valid,   // write request
  output logic              in_ready,   // room available
  input  wire logic [W-1:0] in_data,    // write data
  output logic              out_valid,  // data available
  input  wire logic         out_ready,  // consumer takes
  output logic [W-1:0]      out_data    // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // honest flags from the occupancy count
  assign in_ready  = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];

  // storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else if (clr) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      if (pop)  rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // asq_fifo
`default_nettype wire

/* core/asq_scan_seq.sv */
`timescale 1ns/10ps
`default_nettype none
module asq_scan_seq import asq_pkg::*; (
  input  wire logic        clk_sys,      // 100 MHz clock
  input  wire logic        rst_n,        // async reset, active low
  input  wire logic [7:0]  reg_addr,     // register byte address
  input  wire logic [31:0] reg_wdata,    // write data
  input  wire logic        reg_wr,       // write strobe
  input  wire logic        reg_rd,       // read strobe
  output logic [31:0]      reg_rdata,    // read data, next cycle
  input  wire logic        hw_trig,      // shared backplane trigger
  input  wire logic        ext_trig,     // external trigger pin
  output logic             adc_start,    // conversion request pulse
  output logic [3:0]       adc_ch,       // channel to convert
  input  wire logic        adc_done,     // conversion finished
  input  wire logic [15:0] adc_data,     // conversion result
  output logic             fifo_irq      // fill-level notification
);

  // next enabled channel after cur, wrapping; cur itself if alone
  function automatic logic [3:0] next_en(input logic [3:0] cur,
                                         input logic [15:0] en);
    logic [3:0] r;
    logic [3:0] k;
    r = cur;
    for (int i = NCH - 1; i >= 1; i--) begin
      k = cur + 4'(i);
      if (en[k]) r = k;
    end
    return r;
  endfunction

  asq_ctrl_t   ctrl;
  logic [15:0] chen;
  logic [31:0] intv;
  asq_state_t  state;
  logic [3:0]  ptr;
  logic        want;
  logic        busy;
  logic        bursting;
  logic [31:0] icnt;
  logic [8:0]  bcnt;
  logic        halted;
  logic [11:0] wr_ptr;
  logic [11:0] rd_ptr;
  logic [12:0] cnt;
  asq_smp_t    store [STORE_DEPTH];
  logic [3:0]  conv_ch;
  wire  [1:0]  rise_v;
  wire  [1:0]  fall_v;
  logic        stg_in_ready;
  logic        stg_valid;
  asq_smp_t    stg_data;

  // register decode
  wire wr_ctrl  = reg_wr & (reg_addr == ADDR_CTRL);
  wire wr_chen  = reg_wr & (reg_addr == ADDR_CHEN);
  wire wr_intv  = reg_wr & (reg_addr == ADDR_INTV);
  wire wr_cmd   = reg_wr & (reg_addr == ADDR_CMD);
  wire cmd_go   = wr_cmd & reg_wdata[CMD_START];
  wire cmd_stop = wr_cmd & reg_wdata[CMD_STOP];
  wire cmd_clr  = wr_cmd & reg_wdata[CMD_CLR];
  wire run      = (state == ST_RUN);

  // trigger inputs: three flops each, a change counts once the last two agree
  wire [1:0] pin_in = {ext_trig, hw_trig};
  genvar g;
  for (g = 0; g < 2; g++) begin : g_sync
    logic [2:0] sh;
    logic       lvl;
    wire        agree = (sh[1] == sh[2]);
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        sh  <= '0;
        lvl <= 1'b0;
      end else begin
        sh <= {sh[1:0], pin_in[g]};
        if (agree) lvl <= sh[2];
      end
    end
    assign rise_v[g] = agree & sh[2] & ~lvl;
    assign fall_v[g] = agree & ~sh[2] & lvl;
  end

  // trigger source selection
  wire ext_edge = ctrl.edge_fall ? fall_v[1] : rise_v[1];
  wire arm_hit  = (ctrl.src == SRC_INT) ? rise_v[0] :
                  (ctrl.src == SRC_EXT) ? ext_edge : 1'b0;

  // pacing: interval never shorter than one burst step
  wire [31:0] intv_eff = (intv < 32'(BURST_CYC)) ? 32'(BURST_CYC) : intv;
  wire        itick    = run & (icnt == '0);
  wire        btick    = bursting & (bcnt == '0);
  wire [3:0]  first_ch = next_en(4'hF, chen);
  wire [3:0]  after_ch = next_en(ptr, chen);
  wire        last_ch  = (after_ch <= ptr);
  // a start stalled by a full stage goes out late; the next tick keeps its own slot
  wire        go       = run & want & ~busy & (chen != '0) & stg_in_ready;
  wire        done_ok  = adc_done & busy;

  // staging buffer between converter and sample store
  wire      pop      = reg_rd & (reg_addr == ADDR_DATA) & (cnt != '0);
  wire      stg_take = stg_valid & ~pop;
  wire      full     = (cnt == 13'(STORE_DEPTH));
  wire      keep     = stg_take & ~halted & ~full;

  asq_fifo #(.W(SMP_W), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clr       (cmd_clr),
    .in_valid  (done_ok),
    .in_ready  (stg_in_ready),
    .in_data   ({conv_ch, adc_data}),
    .out_valid (stg_valid),
    .out_ready (~pop),
    .out_data  (stg_data)
  );

  assign adc_start = go;
  assign adc_ch    = ptr;

  // fill threshold from level code
  wire [12:0] thr = (ctrl.lvl == 3'h7) ? THR_TOP : (THR_MIN << ctrl.lvl);

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= asq_ctrl_t'(CTRL_RST);
      chen <= CHEN_RST;
      intv <= INTV_RST;
    end else begin
      if (wr_ctrl) ctrl <= asq_ctrl_t'(reg_wdata[7:0]);
      if (wr_chen) chen <= reg_wdata[15:0];
      if (wr_intv) intv <= reg_wdata;
    end
  end

  // scan state: start, arm, stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (cmd_stop) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:  if (cmd_go) state <= (ctrl.src == SRC_SW) ? ST_RUN : ST_ARMED;
        ST_ARMED: if (arm_hit) state <= ST_RUN;
        ST_RUN:   state <= ST_RUN;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // interval and burst-step counters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      icnt <= '0;
      bcnt <= '0;
    end else begin
      icnt <= (!run || icnt == intv_eff - 1) ? '0 : icnt + 1'b1;
      if (!bursting || itick || bcnt == 9'(BURST_CYC - 1)) bcnt <= '0;
      else bcnt <= bcnt + 1'b1;
    end
  end

  // channel walk; a tick that meets a start keeps its request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr      <= '0;
      want     <= 1'b0;
      busy     <= 1'b0;
      bursting <= 1'b0;
      conv_ch  <= '0;
    end else begin
      if (!run) begin
        want     <= 1'b0;
        bursting <= 1'b0;
        ptr      <= first_ch;
      end else if ((itick && !ctrl.burst) || btick) begin
        want <= 1'b1;
      end else if (go) begin
        want <= 1'b0;
      end
      if (run && itick && ctrl.burst) begin
        bursting <= 1'b1;
        ptr      <= first_ch;
      end else if (run && done_ok) begin
        ptr <= after_ch;
        if (last_ch) bursting <= 1'b0;
      end
      // the channel rides with its conversion, since ptr moves on stop
      if (go) conv_ch <= ptr;
      if (go) busy <= 1'b1;
      else if (adc_done) busy <= 1'b0;
    end
  end

  // sample store memory, written in conversion order
  always_ff @(posedge clk_sys) begin
    if (keep) store[wr_ptr] <= stg_data;
  end

  // store pointers; a full store latches the discard state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
      halted <= 1'b0;
    end else if (cmd_clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
      halted <= 1'b0;
    end else begin
      if (keep) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      cnt <= cnt + 13'(keep) - 13'(pop);
      if (stg_take && full) halted <= 1'b1;
    end
  end

  // read data, one cycle after the strobe
  wire [31:0] stat_w = {3'b000, cnt, 11'h000, fifo_irq, full, halted, state};
  wire [31:0] data_w = {1'b1, 11'h000, store[rd_ptr]};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= {24'h00_0000, ctrl};
        ADDR_CHEN: reg_rdata <= {16'h0000, chen};
        ADDR_INTV: reg_rdata <= intv;
        ADDR_STAT: reg_rdata <= stat_w;
        ADDR_DATA: reg_rdata <= pop ? data_w : '0;
        default:   reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // level notification, only in interrupt transfer mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) fifo_irq <= 1'b0;
    else fifo_irq <= ctrl.irq_en & (cnt >= thr);
  end

  // checks on pacing, triggers and the store
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  localparam int GAP_MIN = BURST_CYC - 1;
  logic [15:0] since;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) since <= 16'hFFFF;
    else if (!run) since <= 16'hFFFF;
    else if (adc_start) since <= '0;
    else if (since != 16'hFFFF) since <= since + 1'b1;
  end

  sequence s_armed_edge;
    (state == ST_ARMED) && arm_hit && !cmd_stop;
  endsequence
  sequence s_running;
    state == ST_RUN;
  endsequence

  a_start_spacing: assert property (
    adc_start |-> since >= 16'(GAP_MIN))
    else $error("conversions closer than the fastest rate");
  a_std_enabled_ch: assert property (
    adc_start |-> chen[adc_ch])
    else $error("conversion on a disabled channel");
  a_burst_next: assert property (
    (done_ok && bursting && !last_ch && run && stg_in_ready) ##1 run [*8]
      |-> ##[1:400] (adc_start || !run || !stg_in_ready))
    else $error("burst step did not follow");
  a_burst_cycle: assert property (
    (itick && ctrl.burst) |=> bursting && (ptr == $past(first_ch)))
    else $error("burst cycle not started on interval");
  a_sw_start: assert property (
    (state == ST_IDLE && cmd_go && !cmd_stop && ctrl.src == SRC_SW)
      |=> s_running ##1 (want || bursting))
    else $error("software start did not run");
  a_armed_go: assert property (
    s_armed_edge |=> s_running)
    else $error("armed scan missed its trigger");
  a_armed_hold: assert property (
    (state == ST_ARMED) |-> !adc_start)
    else $error("conversion while waiting for trigger");
  a_full_discard: assert property (
    (halted && !cmd_clr && !pop) |=> $stable(cnt) && $stable(wr_ptr))
    else $error("sample stored after overflow");
  a_store_bound: assert property (
    cnt <= 13'(STORE_DEPTH))
    else $error("store count beyond capacity");
  a_irq_level: assert property (
    (ctrl.irq_en && cnt >= thr && !cmd_clr && !wr_ctrl) ##1 $stable(cnt) |-> fifo_irq)
    else $error("fill notification missing");
  a_ptr_wrap: assert property (
    (run && done_ok && last_ch && !ctrl.burst && !itick && !wr_chen && !cmd_stop)
      |=> ptr == $past(first_ch))
    else $error("channel pointer did not wrap");

  // bus, stop and trigger-polarity checks
  a_rdata_zero: assert property (
    !reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data outside its slot");
  a_stop_idle: assert property (
    cmd_stop |=> (state == ST_IDLE))
    else $error("scan did not stop");
  a_one_flight: assert property (
    busy |-> !adc_start)
    else $error("second conversion while one is in flight");
  a_irq_poll: assert property (
    !ctrl.irq_en |=> !fifo_irq)
    else $error("notification raised in polling mode");
  a_store_step: assert property (
    (keep && !cmd_clr) |=> (wr_ptr == $past(wr_ptr) + 12'h001))
    else $error("store write pointer skipped");
  a_ext_edge: assert property (
    (state == ST_ARMED && ctrl.src == SRC_EXT && ext_edge && !cmd_stop) |=> s_running)
    else $error("selected external edge missed");
  a_ext_hold: assert property (
    (state == ST_ARMED && ctrl.src == SRC_EXT && !ext_edge) |=> (state != ST_RUN))
    else $error("scan started without its external edge");

endmodule // asq_scan_seq
`default_nettype wire

/* tb/asq_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module asq_adc_model #(
  parameter int LAT = 20
) (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        rst_n,     // async reset
  input  wire logic        adc_start, // conversion request
  input  wire logic [3:0]  adc_ch,    // channel to convert
  output logic             adc_done,  // result pulse
  output logic [15:0]      adc_data   // result word
);
  logic        busy;
  logic [7:0]  cnt;
  logic [3:0]  ch_q;
  logic [11:0] seq;

  // result = {channel, running conversion index}; data toggles when not valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      cnt      <= 8'h00;
      ch_q     <= 4'h0;
      seq      <= 12'h000;
      adc_done <= 1'b0;
      adc_data <= 16'hFFFF;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start && !busy) begin
        busy <= 1'b1;
        cnt  <= 8'(LAT);
        ch_q <= adc_ch;
      end else if (busy && cnt == 8'h01) begin
        busy     <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= {ch_q, seq};
        seq      <= seq + 12'h001;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // asq_adc_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top import asq_pkg::*; ();
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        hw_trig = 1'b0;
  logic        ext_trig = 1'b0;
  logic [31:0] reg_rdata;
  logic        adc_start;
  logic [3:0]  adc_ch;
  logic        adc_done;
  logic [15:0] adc_data;
  logic        fifo_irq;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          st_t[$];
  logic [3:0]  st_c[$];
  logic [31:0] v;
  int          b;

  always #5 clk_sys = ~clk_sys;

  asq_scan_seq u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hw_trig(hw_trig), .ext_trig(ext_trig), .adc_start(adc_start), .adc_ch(adc_ch),
    .adc_done(adc_done), .adc_data(adc_data), .fifo_irq(fifo_irq));

  asq_adc_model #(.LAT(20)) u_adc (.clk_sys(clk_sys), .rst_n(rst_n),
    .adc_start(adc_start), .adc_ch(adc_ch), .adc_done(adc_done), .adc_data(adc_data));

  // log every conversion request with its cycle number
  always @(posedge clk_sys) begin
    if (adc_start === 1'b1) begin
      st_t.push_back(cyc);
      st_c.push_back(adc_ch);
    end
    cyc++;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_starts(input int n, input int lim);
    int k;
    k = 0;
    while (st_t.size() < n && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    chk("start count", st_t.size(), n);
  endtask

  task automatic cnt_is(input int n);
    logic [31:0] s;
    rd(ADDR_STAT, s);
    chk("count", {19'h0, s[28:16]}, n);
  endtask

  // host drains promptly so nothing overflows
  task automatic drain(input int b0, input int n);
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      rd(ADDR_DATA, d);
      chk("sample", d, {1'b1, 11'h000, st_c[b0+i], st_c[b0+i], 12'(b0 + i)});
    end
  endtask

  task automatic chk_starts(input int b0, input int n, input int nch, input int stp,
                            input int gin, input int gwr);
    for (int i = 0; i < n; i++) begin
      chk("channel", {28'h000_0000, st_c[b0+i]}, 32'((i % nch) * stp));
      if (i > 0) begin
        chk("gap", st_t[b0+i] - st_t[b0+i-1], (i % nch == 0) ? gwr : gin);
      end
    end
  endtask

  task automatic pin(input int s, input logic p);
    if (s == 0) begin
      hw_trig <= p;
    end else begin
      ext_trig <= p;
    end
  endtask

  // hang guard, well past the expected run of about 8k cycles
  initial begin
    #(60_000 * 10);
    n_mismatch++;
    results();
  end

  initial begin
    idle(20);
    rst_n <= 1'b1;
    // reset values, unmapped space, empty store
    rd(ADDR_CTRL, v);
    chk("ctrl", v, {24'h00_0000, CTRL_RST});
    rd(ADDR_CHEN, v);
    chk("chen", v, {16'h0000, CHEN_RST});
    rd(ADDR_INTV, v);
    chk("intv", v, INTV_RST);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, v);
    chk("unmapped", v, 32'h0000_0000);
    rd(ADDR_DATA, v);
    chk("empty pop", v, 32'h0000_0000);
    // standard mode over channels 0 and 2
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CHEN, 32'h0000_0005);
    wr(ADDR_INTV, 32'h0000_0190);
    b = st_t.size();
    wr(ADDR_CMD, 32'h0000_0001);
    wait_starts(b + 5, 2400);
    wr(ADDR_CMD, 32'h0000_0002);
    idle(100);
    chk_starts(b, 5, 2, 2, 400, 400);
    cnt_is(5);
    drain(b, 5);
    // burst mode over channels 0..2, cycle every 2000 clocks
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_CHEN, 32'h0000_0007);
    wr(ADDR_INTV, 32'h0000_07D0);
    b = st_t.size();
    wr(ADDR_CMD, 32'h0000_0001);
    wait_starts(b + 6, 4500);
    wr(ADDR_CMD, 32'h0000_0002);
    idle(100);
    chk_starts(b, 6, 3, 1, 400, 1200);
    drain(b, 6);
    // triggers: backplane, external rising, external falling; wrong edge first
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_CTRL, (s == 0) ? 32'h0000_0002 : (s == 1) ? 32'h0000_0004 : 32'h0000_000C);
      pin(s, s != 2);
      idle(10);
      b = st_t.size();
      wr(ADDR_CMD, 32'h0000_0001);
      rd(ADDR_STAT, v);
      chk("armed", {30'h0, v[1:0]}, 32'h0000_0001);
      pin(s, s == 2);
      idle(30);
      chk("held", st_t.size(), b);
      pin(s, s != 2);
      wait_starts(b + 1, 12);
      wr(ADDR_CMD, 32'h0000_0002);
      idle(60);
      drain(b, 1);
    end
    // fill-level notification at 8 samples, then polling and clear
    wr(ADDR_CTRL, 32'h0000_0010);
    wr(ADDR_CHEN, 32'h0000_0001);
    wr(ADDR_INTV, 32'h0000_0190);
    b = st_t.size();
    wr(ADDR_CMD, 32'h0000_0001);
    wait_starts(b + 8, 3600);
    chk("irq at 7", {31'h0, fifo_irq}, 32'h0000_0000);
    idle(40);
    chk("irq at 8", {31'h0, fifo_irq}, 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0030);
    idle(3);
    chk("irq lvl1", {31'h0, fifo_irq}, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0000);
    idle(3);
    chk("irq poll", {31'h0, fifo_irq}, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0010);
    idle(60);
    chk("irq back", {31'h0, fifo_irq}, 32'h0000_0001);
    drain(b, 1);
    idle(3);
    chk("irq drop", {31'h0, fifo_irq}, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0004);
    cnt_is(0);
    rd(ADDR_DATA, v);
    chk("cleared", v, 32'h0000_0000);
    results();
  end
endmodule // tb_top
`default_nettype wire
